// ### design/arb_consts.svh
// Purpose: offsets, field positions and reset values of the result register bank
// Assumes: register offsets are 8-bit word addresses on the serial register path
// Notes: definitions only
`ifndef ARB_CONSTS_SVH
`define ARB_CONSTS_SVH

`define ARB_REG_W           24
`define ARB_FIELD_W         10
`define ARB_UP_LSB          10
`define ARB_UP_MSB          19
`define ARB_LO_LSB          0
`define ARB_LO_MSB          9
`define ARB_RSV_MSB         23
`define ARB_RSV_LSB         20
`define ARB_RESET_VAL       24'h000000
`define ARB_FIELD_RESET     10'h000
`define ARB_OFS_IN12_13     8'h10
`define ARB_OFS_IN14_15     8'h11
`define ARB_OFS_IN16_17     8'h12
`define ARB_OFS_IN18_19     8'h13
`define ARB_OFS_IN20_21     8'h14
`define ARB_OFS_IN22_23     8'h15
`define ARB_OFS_SELF_SUPPLY 8'h16
`define ARB_PAIR_COUNT      6
`define ARB_FIRST_INPUT     12

`endif

// ### design/arb_pkg.sv
// Purpose: shared types of the result register bank
// Assumes: nothing beyond the constants header
// Notes: types only
package arb_pkg;
  typedef logic [9:0]  arb_field_t;
  typedef logic [23:0] arb_word_t;
  typedef enum logic {
    ARB_DIV_THREE,
    ARB_DIV_TEN
  } arb_divider_t;
endpackage

// ### design/arb_result_field.sv
// Purpose: one 10-bit conversion result holder
// Assumes: result data is stable in the cycle its strobe is high
// Notes: gated by an enable so disabled features keep their last value
`timescale 1ns/1ps
`include "arb_consts.svh"

module arb_result_field
  import arb_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_enable,
  input  wire logic       i_strobe,
  input  wire arb_field_t i_data,
  output arb_field_t      o_value
);

  arb_field_t value_q;

  // whole field captured on one edge, never bit by bit
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      value_q <= `ARB_FIELD_RESET;
    end else if (i_strobe && i_enable) begin
      value_q <= i_data;
    end
  end

  assign o_value = value_q;

endmodule

// ### design/arb_result_bank.sv
// Purpose: read-only analog result registers for inputs 12..23, selfcheck and supply
// Assumes: converter and poll sequencer drive completion strobes; serial framing decodes addresses
// Notes: host writes have no effect on any location here
`timescale 1ns/1ps
`include "arb_consts.svh"

// Behaviour
// - 24-bit register, upper field bits 19:10, reserved zero
// - lower field bits 9:0, even input of pair
// - result registers read-only, host writes ignored
// - all bits clear to zero on reset
// - pair registers at 10h..15h, inputs 12..23
// - offset 16h upper field holds selfcheck result
// - offset 16h lower field holds supply result
// - supply result only when measurement enabled
// - selfcheck result only when diagnostic enabled
module arb_result_bank
  import arb_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic [23:0] i_input_done,
  input  wire arb_field_t  i_input_data,
  input  wire logic        i_selfcheck_done,
  input  wire arb_field_t  i_selfcheck_data,
  input  wire logic        i_supply_done,
  input  wire arb_field_t  i_supply_data,
  input  wire logic        i_converter_selfcheck_enable,
  input  wire logic        i_supply_measure_enable,
  input  wire logic        i_supply_divider_select,
  input  wire logic        i_rd_en,
  input  wire logic [7:0]  i_addr,
  input  wire logic        i_wr_en,
  input  wire arb_word_t   i_wr_data,
  output arb_word_t        o_rd_data,
  output logic             o_rd_hit,
  output arb_divider_t     o_supply_divider
);

  // one holder per input 12..23; index 0 carries input 12
  arb_field_t input_result [12];
  arb_field_t converter_selfcheck_result;
  arb_field_t supply_voltage_result;

  arb_field_t input_twelve_result;
  arb_field_t input_thirteen_result;
  arb_field_t input_fourteen_result;
  arb_field_t input_fifteen_result;
  arb_field_t input_sixteen_result;
  arb_field_t input_seventeen_result;
  arb_field_t input_eighteen_result;
  arb_field_t input_nineteen_result;
  arb_field_t input_twenty_result;
  arb_field_t input_twentyone_result;
  arb_field_t input_twentytwo_result;
  arb_field_t input_twentythree_result;

  arb_word_t  result_inputs_12_13;
  arb_word_t  result_inputs_14_15;
  arb_word_t  result_inputs_16_17;
  arb_word_t  result_inputs_18_19;
  arb_word_t  result_inputs_20_21;
  arb_word_t  result_inputs_22_23;
  arb_word_t  result_selfcheck_supply;

  arb_word_t  rd_data_q;
  arb_word_t  rd_data_d;
  logic       rd_hit_d;

  // only inputs 12..23 live here; lower strobes belong to another bank
  genvar g;
  generate
    for (g = 0; g < 12; g = g + 1) begin : g_input
      arb_result_field u_field (
        .i_clk    (i_clk),
        .i_nrst   (i_nrst),
        .i_enable (1'b1),
        .i_strobe (i_input_done[g + `ARB_FIRST_INPUT]),
        .i_data   (i_input_data),
        .o_value  (input_result[g])
      );
    end
  endgenerate

  arb_result_field u_selfcheck (
    .i_clk    (i_clk),
    .i_nrst   (i_nrst),
    .i_enable (i_converter_selfcheck_enable),
    .i_strobe (i_selfcheck_done),
    .i_data   (i_selfcheck_data),
    .o_value  (converter_selfcheck_result)
  );

  arb_result_field u_supply (
    .i_clk    (i_clk),
    .i_nrst   (i_nrst),
    .i_enable (i_supply_measure_enable),
    .i_strobe (i_supply_done),
    .i_data   (i_supply_data),
    .o_value  (supply_voltage_result)
  );

  // divider factor chosen by configuration steers the converter front end
  assign o_supply_divider = i_supply_divider_select ? ARB_DIV_TEN : ARB_DIV_THREE;

  assign input_twelve_result      = input_result[0];
  assign input_thirteen_result    = input_result[1];
  assign input_fourteen_result    = input_result[2];
  assign input_fifteen_result     = input_result[3];
  assign input_sixteen_result     = input_result[4];
  assign input_seventeen_result   = input_result[5];
  assign input_eighteen_result    = input_result[6];
  assign input_nineteen_result    = input_result[7];
  assign input_twenty_result      = input_result[8];
  assign input_twentyone_result   = input_result[9];
  assign input_twentytwo_result   = input_result[10];
  assign input_twentythree_result = input_result[11];

  // reserved bits come from the zero start value, never from a holder
  always_comb begin
    result_inputs_12_13 = `ARB_RESET_VAL;
    result_inputs_12_13[`ARB_UP_MSB:`ARB_UP_LSB] = input_thirteen_result;
    result_inputs_12_13[`ARB_LO_MSB:`ARB_LO_LSB] = input_twelve_result;
  end

  always_comb begin
    result_inputs_14_15 = `ARB_RESET_VAL;
    result_inputs_14_15[`ARB_UP_MSB:`ARB_UP_LSB] = input_fifteen_result;
    result_inputs_14_15[`ARB_LO_MSB:`ARB_LO_LSB] = input_fourteen_result;
  end

  always_comb begin
    result_inputs_16_17 = `ARB_RESET_VAL;
    result_inputs_16_17[`ARB_UP_MSB:`ARB_UP_LSB] = input_seventeen_result;
    result_inputs_16_17[`ARB_LO_MSB:`ARB_LO_LSB] = input_sixteen_result;
  end

  always_comb begin
    result_inputs_18_19 = `ARB_RESET_VAL;
    result_inputs_18_19[`ARB_UP_MSB:`ARB_UP_LSB] = input_nineteen_result;
    result_inputs_18_19[`ARB_LO_MSB:`ARB_LO_LSB] = input_eighteen_result;
  end

  always_comb begin
    result_inputs_20_21 = `ARB_RESET_VAL;
    result_inputs_20_21[`ARB_UP_MSB:`ARB_UP_LSB] = input_twentyone_result;
    result_inputs_20_21[`ARB_LO_MSB:`ARB_LO_LSB] = input_twenty_result;
  end

  always_comb begin
    result_inputs_22_23 = `ARB_RESET_VAL;
    result_inputs_22_23[`ARB_UP_MSB:`ARB_UP_LSB] = input_twentythree_result;
    result_inputs_22_23[`ARB_LO_MSB:`ARB_LO_LSB] = input_twentytwo_result;
  end

  always_comb begin
    result_selfcheck_supply = `ARB_RESET_VAL;
    result_selfcheck_supply[`ARB_UP_MSB:`ARB_UP_LSB] = converter_selfcheck_result;
    result_selfcheck_supply[`ARB_LO_MSB:`ARB_LO_LSB] = supply_voltage_result;
  end

  // write port left unread on purpose: no path into any result holder
  // a write never touches rd_data_q either, so a pending snapshot survives

  // hit decode kept apart from the data mux so it stays purely address driven
  always_comb begin
    rd_hit_d = 1'b0;
    unique case (i_addr)
      `ARB_OFS_IN12_13:     rd_hit_d = 1'b1;
      `ARB_OFS_IN14_15:     rd_hit_d = 1'b1;
      `ARB_OFS_IN16_17:     rd_hit_d = 1'b1;
      `ARB_OFS_IN18_19:     rd_hit_d = 1'b1;
      `ARB_OFS_IN20_21:     rd_hit_d = 1'b1;
      `ARB_OFS_IN22_23:     rd_hit_d = 1'b1;
      `ARB_OFS_SELF_SUPPLY: rd_hit_d = 1'b1;
      default:              rd_hit_d = 1'b0;
    endcase
  end

  // unmapped offsets read as zero
  always_comb begin
    rd_data_d = `ARB_RESET_VAL;
    unique case (i_addr)
      `ARB_OFS_IN12_13:     rd_data_d = result_inputs_12_13;
      `ARB_OFS_IN14_15:     rd_data_d = result_inputs_14_15;
      `ARB_OFS_IN16_17:     rd_data_d = result_inputs_16_17;
      `ARB_OFS_IN18_19:     rd_data_d = result_inputs_18_19;
      `ARB_OFS_IN20_21:     rd_data_d = result_inputs_20_21;
      `ARB_OFS_IN22_23:     rd_data_d = result_inputs_22_23;
      `ARB_OFS_SELF_SUPPLY: rd_data_d = result_selfcheck_supply;
      default:              rd_data_d = `ARB_RESET_VAL;
    endcase
  end

  // read data registered so a snapshot is stable for the whole serial shift-out
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_data_q <= `ARB_RESET_VAL;
    end else if (i_rd_en) begin
      rd_data_q <= rd_data_d;
    end
  end

  assign o_rd_data = rd_data_q;
  assign o_rd_hit  = rd_hit_d;

endmodule

// ### verification/arb_result_bank_properties.sv
// Purpose: port checks of the result bank
// Assumes: one clock, async active-low reset
// Notes: read data is a snapshot one cycle after the request
`timescale 1ns/1ps
module arb_props import arb_pkg::*; (input wire logic i_clk, i_nrst, i_rd_en, i_wr_en, o_rd_hit,
  i_supply_divider_select, input wire logic [23:0] i_input_done, input wire logic [7:0] i_addr,
  input wire arb_field_t i_input_data, input wire arb_word_t o_rd_data, input wire arb_divider_t o_supply_divider);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  property p_rsv; o_rd_data[23:20] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_hit; o_rd_hit == (i_addr inside {[8'h10:8'h16]}); endproperty
  a_hit: assert property (p_hit) else $error("bad hit");
  property p_miss; i_rd_en && !o_rd_hit |=> o_rd_data == 24'h000000; endproperty
  a_miss: assert property (p_miss) else $error("unmapped data");
  property p_wr; i_wr_en && !i_rd_en |=> $stable(o_rd_data); endproperty
  a_wr: assert property (p_wr) else $error("write took");
  property p_div; o_supply_divider == arb_divider_t'(i_supply_divider_select); endproperty
  a_div: assert property (p_div) else $error("bad divider");
  property p_lo; i_input_done == 24'h001000 ##2 i_rd_en && i_addr == 8'h10
    |=> o_rd_data[9:0] == $past(i_input_data, 3); endproperty
  a_lo: assert property (p_lo) else $error("bad low field");
  property p_up; i_input_done == 24'h002000 ##4 i_rd_en && i_addr == 8'h10
    |=> o_rd_data[19:10] == $past(i_input_data, 5); endproperty
  a_up: assert property (p_up) else $error("bad high field");
  property p_rst; !$past(i_nrst) |-> o_rd_data == 24'h000000; endproperty
  a_rst: assert property (p_rst) else $error("not cleared");
endmodule
bind arb_result_bank arb_props arb_props_inst(.*);

// ### verification/arb_host_model.sv
// Purpose: host side of the register path
// Assumes: one request at a time, launched on rising edges
// Notes: address is inverted once released
`timescale 1ns/1ps
module arb_host_model(input wire logic i_clk, output logic o_rd_en, output logic o_wr_en,
  output logic [7:0] o_addr, output logic [23:0] o_wr_data, input wire logic [23:0] i_rd_data,
  input wire logic i_rd_hit);
  initial begin o_rd_en = 0; o_wr_en = 0; o_addr = 8'h00; o_wr_data = 24'h000000; end
  // hit taken at the request edge while the address still stands
  task rd(logic [7:0] a, output logic [23:0] d, output logic h);
    @(posedge i_clk); o_rd_en <= 1'b1; o_addr <= a;
    @(posedge i_clk); h = i_rd_hit; o_rd_en <= 1'b0; o_addr <= ~a;
    @(negedge i_clk); d = i_rd_data;
  endtask
  task wr(logic [7:0] a, logic [23:0] x);
    @(posedge i_clk); o_wr_en <= 1'b1; o_addr <= a; o_wr_data <= x;
    @(posedge i_clk); o_wr_en <= 1'b0; o_addr <= ~a; o_wr_data <= ~x;
  endtask
endmodule

// ### verification/arb_result_bank_tb_top.sv
// Purpose: directed bench of the result bank
// Assumes: supply data is the inverse of the shared data bus
// Notes: hit and divider outputs are checked beside the read data
`timescale 1ns/1ps
module arb_result_bank_tb_top;
  logic i_clk = 0, i_nrst = 0, i_selfcheck_done = 0, i_supply_done = 0, i_converter_selfcheck_enable = 0;
  logic i_supply_measure_enable = 0, i_supply_divider_select = 0, i_rd_en, i_wr_en, o_rd_hit, o_supply_divider;
  logic [23:0] i_input_done = 0, i_wr_data, o_rd_data, got;
  logic [9:0] i_input_data = 0, i_selfcheck_data, i_supply_data;
  logic [7:0] i_addr;
  logic hit;
  int miscompares = 0, compares = 0, cyc = 0;
  assign i_selfcheck_data = i_input_data;
  assign i_supply_data = ~i_input_data;
  initial forever #4 i_clk = ~i_clk;
  arb_host_model arb_host_model_inst(.i_clk, .o_rd_en(i_rd_en), .o_wr_en(i_wr_en), .o_addr(i_addr),
    .o_wr_data(i_wr_data), .i_rd_data(o_rd_data), .i_rd_hit(o_rd_hit));
  arb_result_bank arb_result_bank_inst(.i_clk(i_clk), .i_nrst(i_nrst), .i_input_done(i_input_done),
    .i_input_data(i_input_data), .i_selfcheck_done(i_selfcheck_done), .i_selfcheck_data(i_selfcheck_data),
    .i_supply_done(i_supply_done), .i_supply_data(i_supply_data),
    .i_converter_selfcheck_enable(i_converter_selfcheck_enable),
    .i_supply_measure_enable(i_supply_measure_enable), .i_supply_divider_select(i_supply_divider_select),
    .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wr_en(i_wr_en), .i_wr_data(i_wr_data),
    .o_rd_data(o_rd_data), .o_rd_hit(o_rd_hit), .o_supply_divider(o_supply_divider));
  function automatic logic [9:0] v(int k); return 10'(k * 41); endfunction
  task st(int k, logic [9:0] x);
    @(posedge i_clk); i_input_data <= x;
    if (k < 24) i_input_done[k] <= 1'b1; else if (k == 24) i_selfcheck_done <= 1'b1; else i_supply_done <= 1'b1;
    @(posedge i_clk); i_input_done <= 24'h000000; i_selfcheck_done <= 1'b0; i_supply_done <= 1'b0;
  endtask
  task chk(logic [7:0] a, logic [23:0] e);
    logic eh;
    eh = (a >= 8'h10) && (a <= 8'h16);
    arb_host_model_inst.rd(a, got, hit);
    compares++;
    if (got !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
    compares++;
    if (hit !== eh) begin
      miscompares++;
      $display("wrong value at %0t: hit got %h expected %h", $time, hit, eh);
    end
  endtask
  task chk_div(logic e);
    @(negedge i_clk);
    compares++;
    if (o_supply_divider !== e) begin
      miscompares++;
      $display("wrong value at %0t: divider got %h expected %h", $time, o_supply_divider, e);
    end
  endtask
  task end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge i_clk) if (++cyc == 1000) begin miscompares++; end_sim; end
  initial begin
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    for (int a = 16; a < 24; a++) chk(8'(a), 24'h000000);
    for (int a = 16; a < 23; a++) arb_host_model_inst.wr(8'(a), 24'hFFFFFF);
    for (int a = 16; a < 23; a++) chk(8'(a), 24'h000000);
    $display("test done: reset and writes");
    for (int j = 12; j < 24; j += 2) begin
      st(j + 1, v(j + 1));
      st(j, v(j));
      chk(8'(j / 2 + 10), {4'h0, v(j + 1), v(j)});
    end
    arb_host_model_inst.wr(8'h10, 24'hFFFFFF);
    chk(8'h10, {4'h0, v(13), v(12)});
    chk_div(1'b0);
    st(24, 10'h155);
    st(25, 10'h0AA);
    chk(8'h16, 24'h000000);
    @(posedge i_clk); i_converter_selfcheck_enable <= 1'b1; i_supply_measure_enable <= 1'b1;
    i_supply_divider_select <= 1'b1;
    chk_div(1'b1);
    st(24, 10'h3FF);
    st(25, 10'h0F0);
    chk(8'h16, {4'h0, 10'h3FF, 10'h30F});
    $display("test done: result fields");
    end_sim;
  end
endmodule
